/* hdl/lic_line_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "lic_defines.vh"
module lic_line_ctrl (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  // Avalon-MM slave
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Hook request from line logic (pin)
  input  wire        i_offhook_req,
  // Line interface controls
  output reg         o_offhook,
  output reg         o_onhook_busy,
  output reg         o_dc_term_off,
  output reg         o_dc_term_pin_low,
  output reg         o_ring_squelch_en,
  output reg         o_ac_term_complex,
  output reg  [1:0]  o_dc_term_mode,
  output reg         o_ringer_synth,
  output reg         o_ring_threshold_high
);

  // ===================================================================
  // Registers
  reg  [7:0]  ctrl1_ff;
  reg         ack_ff;
  reg  [15:0] div_ff;
  reg         tick_ff;
  reg  [12:0] onhook_cnt_ff;
  reg         hook_ff;
  wire        req_sync;
  wire        access;
  wire        ctrl_sel;
  reg  [31:0] nxt_rdata;

  lic_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_offhook_req),
    .o_level   (req_sync)
  );

  // ===================================================================
  // Bus slave: one wait cycle per access
  assign access            = (i_avs_read | i_avs_write) & ~ack_ff;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
  assign ctrl_sel          = (i_avs_address == `LIC_ADDR_CTRL1);

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= access;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl1_ff <= `LIC_CTRL1_RESET;
    end else if (ack_ff & i_avs_write & ctrl_sel & i_avs_byteenable[0]) begin
      // Lands only at the edge where waitrequest is low
      // Reserved bit 4 stays zero
      ctrl1_ff <= i_avs_writedata[7:0] & `LIC_CTRL1_WMASK;
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (i_avs_address)
      `LIC_ADDR_CTRL1:  nxt_rdata[7:0] = ctrl1_ff;
      `LIC_ADDR_STATUS: nxt_rdata[7:0] = {o_ring_squelch_en, o_dc_term_off,
                                          o_onhook_busy, 4'h0, o_offhook};
      `LIC_ADDR_HOOK:   nxt_rdata[12:0] = onhook_cnt_ff;
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (access & i_avs_read) begin
      o_avs_readdata <= nxt_rdata;
    end
  end

  // ===================================================================
  // Sample-rate tick divider
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == `LIC_SAMPLE_DIV - 16'h0001) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // ===================================================================
  // Hook state and on-hook counter
  // Off-hook state holds until the counter expires, so the line is
  // released at the selected speed rather than at once.
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hook_ff       <= 1'b0;
      onhook_cnt_ff <= 13'h0000;
    end else if (req_sync) begin
      hook_ff       <= 1'b1;
      onhook_cnt_ff <= 13'h0000;
    end else if (hook_ff) begin
      if (onhook_cnt_ff == 13'h0000) begin
        onhook_cnt_ff <= ctrl1_ff[`LIC_BIT_ONHOOK_SPD] ? `LIC_ONHOOK_SLOW : `LIC_ONHOOK_FAST; // R4
      end else if (tick_ff) begin
        if (onhook_cnt_ff == 13'h0001) begin
          hook_ff <= 1'b0; // R4
        end
        onhook_cnt_ff <= onhook_cnt_ff - 13'h0001;
      end
    end
  end

  // ===================================================================
  // Line interface outputs
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_offhook             <= 1'b0;
      o_onhook_busy         <= 1'b0;
      o_dc_term_off         <= 1'b0;
      o_dc_term_pin_low     <= 1'b0;
      o_ring_squelch_en     <= 1'b0;
      o_ac_term_complex     <= 1'b0;
      o_dc_term_mode        <= `LIC_DC_MODE_LOWV;
      o_ringer_synth        <= 1'b0;
      o_ring_threshold_high <= 1'b0;
    end else begin
      o_offhook             <= hook_ff;
      o_onhook_busy         <= hook_ff & ~req_sync;
      o_dc_term_off         <= hook_ff & ctrl1_ff[`LIC_BIT_TERM_SQL]; // R1
      o_dc_term_pin_low     <= hook_ff & ctrl1_ff[`LIC_BIT_TERM_SQL]; // R1
      o_ring_squelch_en     <= ~hook_ff & ctrl1_ff[`LIC_BIT_TERM_SQL]; // R2
      o_ac_term_complex     <= ctrl1_ff[`LIC_BIT_AC_TERM]; // R5
      o_dc_term_mode        <= ctrl1_ff[`LIC_BIT_DC_MODE_HI:`LIC_BIT_DC_MODE_LO]; // R6
      o_ringer_synth        <= ctrl1_ff[`LIC_BIT_RINGER]; // R7
      o_ring_threshold_high <= ctrl1_ff[`LIC_BIT_RING_THR]; // R8
    end
  end

endmodule // lic_line_ctrl
`default_nettype wire

/* hdl/lic_defines.vh */
// Contract
// (R1) Off-hook with bit 7 set: dc termination off, 800 ohm, lowered pin voltage.
// (R2) On-hook, bit 7 enables the enhanced ring-detect squelch.
// (R3) Software sets squelch after reversal or ring, clears before next ring.
// (R4) On-hook speed bit picks 1024 or 4096 sample periods for on-hook.
// (R5) Ac termination bit: zero real impedance, one complex impedance.
// (R6) Two-bit dc termination field selects low, lower, standard or current-limit mode.
// (R7) Ringer bit: zero maximum, one synthesized; synthesized only without external parts.
// (R8) Ring threshold bit picks 11-22 or 17-33 V rms detection window.
`ifndef LIC_DEFINES_VH
`define LIC_DEFINES_VH

// =====================================================================
// Register map (byte addresses, word aligned)
`define LIC_ADDR_CTRL1      8'h10
`define LIC_ADDR_STATUS     8'h14
`define LIC_ADDR_HOOK       8'h18
`define LIC_CTRL1_RESET     8'h00
`define LIC_CTRL1_WMASK     8'hEF

// =====================================================================
// Field positions of the control register
`define LIC_BIT_TERM_SQL    7
`define LIC_BIT_ONHOOK_SPD  6
`define LIC_BIT_AC_TERM     5
`define LIC_BIT_DC_MODE_HI  3
`define LIC_BIT_DC_MODE_LO  2
`define LIC_BIT_RINGER      1
`define LIC_BIT_RING_THR    0

// =====================================================================
// Dc termination modes
`define LIC_DC_MODE_LOWV    2'h0
`define LIC_DC_MODE_LOWERV  2'h1
`define LIC_DC_MODE_STD     2'h2
`define LIC_DC_MODE_ILIM    2'h3

// =====================================================================
// On-hook timing in sample periods, sample divider in clocks
`define LIC_ONHOOK_FAST     13'h0400
`define LIC_ONHOOK_SLOW     13'h1000
`define LIC_SAMPLE_DIV      16'h0A2C

`endif

/* hdl/lic_sync.v */
`timescale 1ns/1ps
`default_nettype none
module lic_sync (
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_sys_rst,
  // Pin in, stable level out
  input  wire i_async,
  output reg  o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Change counts only when second and third agree
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end
endmodule // lic_sync
`default_nettype wire

/* tb/lic_hook_line.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// Line-side hook request, changes just after an edge
module lic_hook_line (
  input  wire logic i_clk_sys,
  input  wire logic i_go,
  output var  logic o_hook
);
  always @(posedge i_clk_sys) o_hook <= i_go;
endmodule // lic_hook_line
`default_nettype wire

/* tb/lic_line_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lic_line_ctrl_sva (
  input wire logic       i_clk_sys, i_sys_rst, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic [7:0] i_avs_address,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic       o_offhook, o_onhook_busy, o_dc_term_off, o_dc_term_pin_low,
  input wire logic       o_ring_squelch_en, o_ac_term_complex, o_ringer_synth,
  input wire logic       o_ring_threshold_high,
  input wire logic [1:0] o_dc_term_mode
);
  // ======
  // Control write taken
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic wr;
  assign wr = i_avs_write & !o_avs_waitrequest & (i_avs_address == 8'h10) & i_avs_byteenable[0];
  property p_ws; (i_avs_read | i_avs_write) & o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_ws: assert property (p_ws) else $error("wait state not one cycle");
  property p_ac; wr |-> ##2 o_ac_term_complex == $past(i_avs_writedata[5], 2); endproperty
  a_ac: assert property (p_ac) else $error("ac select wrong");
  property p_dcm; wr |-> ##2 o_dc_term_mode == $past(i_avs_writedata[3:2], 2); endproperty
  a_dcm: assert property (p_dcm) else $error("dc mode wrong");
  property p_ringer; wr |-> ##2 o_ringer_synth == $past(i_avs_writedata[1], 2); endproperty
  a_ringer: assert property (p_ringer) else $error("ringer select wrong");
  property p_thr; wr |-> ##2 o_ring_threshold_high == $past(i_avs_writedata[0], 2); endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_toff_hook; o_dc_term_off |-> o_offhook; endproperty
  a_toff_hook: assert property (p_toff_hook) else $error("termination off while on-hook");
  property p_sql_hook; o_ring_squelch_en |-> !o_offhook; endproperty
  a_sql_hook: assert property (p_sql_hook) else $error("squelch while off-hook");
  property p_off; o_dc_term_off == o_dc_term_pin_low; endproperty
  a_off: assert property (p_off) else $error("termination pair split");
  property p_sql; !(o_ring_squelch_en & o_dc_term_off); endproperty
  a_sql: assert property (p_sql) else $error("squelch while off-hook");
  property p_busy; o_onhook_busy |-> o_offhook; endproperty
  a_busy: assert property (p_busy) else $error("release count on-hook");
endmodule // lic_line_ctrl_sva
bind lic_line_ctrl lic_line_ctrl_sva i_lic_line_ctrl_sva (.*);
`default_nettype wire

/* tb/line_interface_control_reg_test.sv */
`timescale 1ns/1ps
`default_nettype none
module line_interface_control_reg_test;
  logic clk = 0, rst = 1, rd = 0, wr = 0, go = 0;
  logic [7:0] adr = 0, d;
  logic [31:0] wd = 0, q, cnt_a, cnt_b;
  logic [3:0] be = 4'h1;
  logic [15:0] r = 16'h0FA0;
  wire logic hook, wq, offh, busy, toff, tlow, sq, ac, rsyn, rthr;
  wire logic [1:0] dm;
  wire logic [31:0] rdata;
  int failures = 0, n_checks = 0, i;
  lic_hook_line i_lic_hook_line (.i_clk_sys(clk), .i_go(go), .o_hook(hook));
  lic_line_ctrl i_lic_line_ctrl (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_offhook_req(hook), .o_offhook(offh),
    .o_onhook_busy(busy), .o_dc_term_off(toff), .o_dc_term_pin_low(tlow),
    .o_ring_squelch_en(sq), .o_ac_term_complex(ac), .o_dc_term_mode(dm),
    .o_ringer_synth(rsyn), .o_ring_threshold_high(rthr));
  initial forever #4 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // ======
  // Bus cycle: launched after an edge, held until waitrequest is seen low at an edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 64);
    q = rdata;
    wr <= 0;
    rd <= 0;
    if (n >= 64) failures++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 4; i++) begin
      r = lfsr(r);
      d = {r[7:4], i[1:0], r[1:0]};
      bus(1, 8'h10, {r[15:8], r[15:8], r[15:8], d});
      bus(0, 8'h10, 0);
      chk(q, {24'h0, d & 8'hEF});
      chk(32'({sq, toff, ac, dm, rsyn, rthr}), 32'({d[7], 1'b0, d[5], d[3:0]}));
    end
    be <= 4'h0;
    bus(1, 8'h10, 32'h0000_00FF);
    be <= 4'h1;
    bus(0, 8'h10, 0);
    chk(q, {24'h0, d & 8'hEF});
    bus(0, 8'h1C, 0);
    chk(q, 0);
    $display("register test done");
    go <= 1;
    repeat (20) @(posedge clk);
    bus(1, 8'h10, 32'h0000_00C0);
    repeat (3) @(posedge clk);
    chk(32'({offh, toff, tlow, sq}), 32'h0000_000E);
    bus(0, 8'h14, 0);
    chk(q, 32'h0000_0041);
    go <= 0;
    repeat (20) @(posedge clk);
    bus(0, 8'h14, 0);
    chk(q, 32'h0000_0061);
    repeat (1000) @(posedge clk);
    chk(32'({offh, busy}), 32'h0000_0003);
    // Slow release: under one sample tick elapsed since the count was loaded
    bus(0, 8'h18, 0);
    cnt_a = q;
    chk(32'(cnt_a == 32'h0000_1000 || cnt_a == 32'h0000_0FFF), 32'h0000_0001);
    // Reads sampled 26040 clocks apart: exactly ten sample ticks of 2604 clocks
    repeat (26037) @(posedge clk);
    bus(0, 8'h18, 0);
    cnt_b = q;
    chk(cnt_a - cnt_b, 32'h0000_000A);
    $display("hook test done");
    rst <= 1;
    repeat (2) @(posedge clk);
    chk(32'({offh, busy, toff, tlow, sq, ac}), 32'h0000_0000);
    rst <= 0;
    bus(0, 8'h10, 0);
    chk(q, 32'h0000_0000);
    $display("reset test done");
    print_verdict;
  end
endmodule // line_interface_control_reg_test
`default_nettype wire
